/* rtl/crfc_core.sv */
// Functional notes
// - 8-bit accumulator, also a data-space location at ff.
// - two 8-bit pointer registers at data addresses 80 and 81.
// - two 8-bit short-direct registers at data addresses 82 and 83.
// - short-direct access fits a one-byte, four-cycle instruction.
// - pointer registers also serve as short-direct operands.
// - program counter is 12 bits, covering 4096 program bytes.
// - program counter steps by one after each fetched byte.
// - relative branch adds signed offset to counter in its own adder, not the alu.
// - counter loads jump/call target, vector, or popped stack value.
// - three carry/zero pairs: normal, interrupt, non-maskable.
// - taking an interrupt switches flag use to its own pair at once.
// - interrupt return restores the pair of the prior context.
// - each pair is reachable only from its own context.
// - context switches never clear any flag pair.
// - carry set on carry or borrow from arithmetic, else cleared.
// - bit test copies tested bit into active carry.
// - rotate left passes through the active carry.
// - zero set when latest arithmetic or logic result is zero.
// - reset starts in the non-maskable context.
// - six-level 12-bit return stack; call pushes, return pops.
// - empty return keeps stack in place; overflow drops oldest entry.
`timescale 1ns/1ps
`default_nettype none
module crfc_core
   import crfc_pkg::*;
#(
   parameter logic [11:0] IRQ_VECTOR = 12'hff0,
   parameter logic [11:0] NMI_VECTOR = 12'hffc,
   parameter logic [11:0] RESET_VECTOR = 12'hffe
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire crfc_dbus_t dbus,
   output logic [7:0] dbus_rdata,
   output logic dbus_hit,
   input wire crfc_pc_op_t pc_op,
   input wire logic [11:0] pc_target,
   input wire logic [7:0] rel_offset,
   input wire crfc_fl_op_t fl_op,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic alu_sub,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] bit_src,
   input wire logic short_sel_valid,
   input wire logic [1:0] short_sel,
   output logic [7:0] short_rdata,
   output logic [7:0] alu_result,
   output logic [11:0] program_counter,
   output crfc_flags_t active_flags,
   output crfc_ctx_t context_out,
   output logic short_cycles_out
);
   crfc_ctx_t ctx_q, ctx_d;
   crfc_ctx_t prev_ctx_q, prev_ctx_d;
   crfc_flags_t pair_q [3];
   logic [7:0] acc_q, acc_d;
   logic [7:0] reg_q [4];
   logic [11:0] pc_q, pc_d;
   logic [7:0] rd_q;
   logic hit_q;
   logic [7:0] res_q;
   crfc_flags_t fl_out_q;
   logic [7:0] short_q;
   logic short_flag_q;

   function automatic logic [1:0] crfc_map(input logic [7:0] a);
      crfc_map = a[1:0];
   endfunction : crfc_map

   function automatic logic crfc_is_file(input logic [7:0] a);
      crfc_is_file = (a >= CRFC_ADDR_PTR0) && (a <= CRFC_ADDR_SHR1);
   endfunction : crfc_is_file

   // address decode
   wire logic hit_acc = (dbus.addr == CRFC_ADDR_ACC);
   wire logic hit_file = crfc_is_file(dbus.addr);
   wire logic [1:0] file_idx = crfc_map(dbus.addr);
   wire logic [7:0] rd_mux = hit_acc ? acc_q : (hit_file ? reg_q[file_idx] : 8'h00);

   // alu: carry and zero from the operation
   crfc_flags_t cur;
   assign cur = pair_q[ctx_q]; // only own context pair is visible
   wire logic [8:0] arith = alu_sub ? ({1'b0, alu_a} - {1'b0, alu_b}) : ({1'b0, alu_a} + {1'b0, alu_b});
   wire logic [8:0] rotl = {alu_a, cur.carry}; // carry is in the rotation path
   wire logic [7:0] logic_res = alu_a & alu_b;
   logic [7:0] res_d;
   crfc_flags_t fl_d;
   always_comb begin
      res_d = res_q;
      fl_d = cur; // keep pair when no flag result
      case (fl_op)
         CRFC_FL_ARITH: begin
            res_d = arith[7:0];
            fl_d.carry = arith[8];
            fl_d.zero = (arith[7:0] == 8'h00);
         end
         CRFC_FL_LOGIC: begin
            res_d = logic_res;
            fl_d.zero = (logic_res == 8'h00);
         end
         CRFC_FL_BITTEST: begin
            fl_d.carry = bit_src[bit_sel];
         end
         CRFC_FL_ROTL: begin
            res_d = rotl[7:0];
            fl_d.carry = rotl[8];
            fl_d.zero = (rotl[7:0] == 8'h00);
         end
         default: begin
         end
      endcase
   end

   // context switching
   always_comb begin
      ctx_d = ctx_q;
      prev_ctx_d = prev_ctx_q;
      case (pc_op)
         CRFC_PC_IRQ: begin
            prev_ctx_d = ctx_q;
            ctx_d = CRFC_CTX_IRQ;
         end
         CRFC_PC_NMI: begin
            prev_ctx_d = ctx_q;
            ctx_d = CRFC_CTX_NMI;
         end
         CRFC_PC_INTERRUPT_RETURN_INSTR: begin
            ctx_d = prev_ctx_q;
            prev_ctx_d = CRFC_CTX_NORMAL;
         end
         default: begin
         end
      endcase
   end

   // program counter sources
   wire logic [11:0] rel_sum = pc_q + {{4{rel_offset[7]}}, rel_offset};
   wire logic stack_push = (pc_op == CRFC_PC_CALL) || (pc_op == CRFC_PC_IRQ) || (pc_op == CRFC_PC_NMI);
   wire logic stack_pop = (pc_op == CRFC_PC_RET) || (pc_op == CRFC_PC_INTERRUPT_RETURN_INSTR);
   logic [11:0] stack_top;
   logic stack_empty;
   always_comb begin
      pc_d = pc_q;
      case (pc_op)
         CRFC_PC_INC: pc_d = pc_q + CRFC_PC_ONE;
         CRFC_PC_REL: pc_d = rel_sum;
         CRFC_PC_JUMP: pc_d = pc_target;
         CRFC_PC_CALL: pc_d = pc_target;
         CRFC_PC_IRQ: pc_d = IRQ_VECTOR;
         CRFC_PC_NMI: pc_d = NMI_VECTOR;
         // empty stack: fall through to the next instruction
         CRFC_PC_RET, CRFC_PC_INTERRUPT_RETURN_INSTR: pc_d = stack_empty ? pc_q + CRFC_PC_ONE : stack_top;
         default: pc_d = pc_q;
      endcase
   end

   crfc_stack #(.DEPTH(CRFC_STACK_DEPTH), .W(CRFC_PC_W)) u_stack (
      .clock(clock),
      .rst_n(rst_n),
      .push(stack_push),
      .pop(stack_pop),
      .push_val(pc_q),
      .top(stack_top),
      .empty(stack_empty)
   );

   // accumulator: bus write wins over alu result in the same cycle
   always_comb begin
      acc_d = acc_q;
      if (fl_op != CRFC_FL_KEEP && fl_op != CRFC_FL_BITTEST) begin
         acc_d = res_d;
      end
      if (dbus.wr && hit_acc) begin
         acc_d = dbus.wdata;
      end
   end

   // short-direct selection covers pointers and short registers alike
   wire logic [7:0] short_mux = reg_q[short_sel];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctx_q <= CRFC_CTX_NMI;
         prev_ctx_q <= CRFC_CTX_NORMAL;
         pc_q <= CRFC_PC_RESET;
         acc_q <= CRFC_REG_RESET;
         for (int i = 0; i < 4; i++) begin
            reg_q[i] <= CRFC_REG_RESET;
         end
         for (int i = 0; i < 3; i++) begin
            pair_q[i] <= '0;
         end
         rd_q <= 8'h00;
         hit_q <= 1'b0;
         res_q <= 8'h00;
         fl_out_q <= '0;
         short_q <= 8'h00;
         short_flag_q <= 1'b0;
      end else begin
         ctx_q <= ctx_d;
         prev_ctx_q <= prev_ctx_d;
         pc_q <= pc_d;
         acc_q <= acc_d;
         if (dbus.wr && hit_file) begin
            reg_q[file_idx] <= dbus.wdata;
         end
         // only the active pair is written; others retain
         pair_q[ctx_q] <= fl_d;
         rd_q <= rd_mux;
         hit_q <= hit_acc || hit_file;
         res_q <= res_d;
         fl_out_q <= pair_q[ctx_d] == pair_q[ctx_q] && ctx_d == ctx_q ? fl_d : pair_q[ctx_d];
         short_q <= short_sel_valid ? short_mux : short_q;
         short_flag_q <= short_sel_valid;
      end
   end

   assign dbus_rdata = rd_q;
   assign dbus_hit = hit_q;
   assign alu_result = res_q;
   assign program_counter = pc_q;
   assign active_flags = fl_out_q;
   assign context_out = ctx_q;
   assign short_rdata = short_q;
   assign short_cycles_out = short_flag_q;

   a_reset_nmi_ctx: assert property (@(posedge clock)
      $rose(rst_n) |-> ctx_q == CRFC_CTX_NMI) else $error("not in nmi context after reset");
   a_pc_increment: assert property (@(posedge clock) disable iff (!rst_n)
      pc_op == CRFC_PC_INC |=> pc_q == $past(pc_q) + CRFC_PC_ONE) else $error("pc did not step");
   a_pc_relative: assert property (@(posedge clock) disable iff (!rst_n)
      pc_op == CRFC_PC_REL |=> pc_q == $past(rel_sum)) else $error("relative branch wrong");
   a_pc_vector: assert property (@(posedge clock) disable iff (!rst_n)
      pc_op == CRFC_PC_IRQ |=> pc_q == IRQ_VECTOR && ctx_q == CRFC_CTX_IRQ) else $error("irq entry wrong");
   a_call_return: assert property (@(posedge clock) disable iff (!rst_n)
      pc_op == CRFC_PC_CALL ##1 pc_op == CRFC_PC_RET |=> pc_q == $past(pc_q, 2)) else $error("call/ret mismatch");
   a_interrupt_return_instr_restore: assert property (@(posedge clock) disable iff (!rst_n)
      pc_op == CRFC_PC_NMI ##1 pc_op == CRFC_PC_INTERRUPT_RETURN_INSTR |=> ctx_q == $past(ctx_q, 2)) else $error("interrupt_return_instr context");
   a_carry_arith: assert property (@(posedge clock) disable iff (!rst_n)
      fl_op == CRFC_FL_ARITH |=> pair_q[$past(ctx_q)].carry == $past(arith[8])) else $error("carry wrong");
   a_zero_arith: assert property (@(posedge clock) disable iff (!rst_n)
      fl_op == CRFC_FL_ARITH |=> pair_q[$past(ctx_q)].zero == ($past(arith[7:0]) == 8'h00)) else $error("zero wrong");
   a_bit_test: assert property (@(posedge clock) disable iff (!rst_n)
      fl_op == CRFC_FL_BITTEST |=> pair_q[$past(ctx_q)].carry == $past(bit_src[bit_sel])) else $error("bit test");
   a_flags_keep: assert property (@(posedge clock) disable iff (!rst_n)
      fl_op == CRFC_FL_KEEP |=> pair_q[$past(ctx_q)] == $past(cur)) else $error("flags changed");
   a_other_pairs: assert property (@(posedge clock) disable iff (!rst_n)
      ctx_q != CRFC_CTX_NORMAL |=> pair_q[CRFC_CTX_NORMAL] == $past(pair_q[CRFC_CTX_NORMAL])) else $error("pair leak");
   a_acc_write: assert property (@(posedge clock) disable iff (!rst_n)
      dbus.wr && hit_acc ##1 !dbus.wr && fl_op == CRFC_FL_KEEP |=> dbus_rdata == $past(dbus.wdata, 2) || !$past(hit_acc))
      else $error("acc readback");

   c_irq_entry: cover property (@(posedge clock) disable iff (!rst_n) pc_op == CRFC_PC_IRQ);
   c_nested_ret: cover property (@(posedge clock) disable iff (!rst_n) pc_op == CRFC_PC_CALL ##1 pc_op == CRFC_PC_RET);
   c_empty_ret: cover property (@(posedge clock) disable iff (!rst_n) pc_op == CRFC_PC_RET && stack_empty);
   c_reg_write: cover property (@(posedge clock) disable iff (!rst_n) dbus.wr && hit_file);
endmodule : crfc_core
`default_nettype wire

/* rtl/crfc_pkg.sv */
package crfc_pkg;
   localparam logic [7:0] CRFC_ADDR_PTR0 = 8'h80;
   localparam logic [7:0] CRFC_ADDR_PTR1 = 8'h81;
   localparam logic [7:0] CRFC_ADDR_SHR0 = 8'h82;
   localparam logic [7:0] CRFC_ADDR_SHR1 = 8'h83;
   localparam logic [7:0] CRFC_ADDR_ACC = 8'hff;
   localparam logic [7:0] CRFC_REG_RESET = 8'h00;
   localparam int CRFC_PC_W = 12;
   localparam int CRFC_STACK_DEPTH = 6;
   localparam logic [11:0] CRFC_PC_RESET = 12'h000;
   localparam logic [11:0] CRFC_PC_ONE = 12'h001;
   localparam int CRFC_SHORT_CYCLES = 4;

   typedef enum logic [1:0] {
      CRFC_CTX_NORMAL,
      CRFC_CTX_IRQ,
      CRFC_CTX_NMI
   } crfc_ctx_t;

   typedef enum logic [3:0] {
      CRFC_PC_HOLD,
      CRFC_PC_INC,
      CRFC_PC_REL,
      CRFC_PC_JUMP,
      CRFC_PC_CALL,
      CRFC_PC_IRQ,
      CRFC_PC_NMI,
      CRFC_PC_RET,
      CRFC_PC_INTERRUPT_RETURN_INSTR
   } crfc_pc_op_t;

   typedef enum logic [2:0] {
      CRFC_FL_KEEP,
      CRFC_FL_ARITH,
      CRFC_FL_LOGIC,
      CRFC_FL_BITTEST,
      CRFC_FL_ROTL
   } crfc_fl_op_t;

   typedef struct packed {
      logic carry;
      logic zero;
   } crfc_flags_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } crfc_dbus_t;
endpackage : crfc_pkg

/* rtl/crfc_stack.sv */
`timescale 1ns/1ps
`default_nettype none
module crfc_stack
   import crfc_pkg::*;
#(
   parameter int DEPTH = CRFC_STACK_DEPTH,
   parameter int W = CRFC_PC_W
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic [W-1:0] push_val,
   output logic [W-1:0] top,
   output logic empty
);
   initial begin
      // the level count is four bits wide, so deeper stacks cannot be tracked
      if (DEPTH < 2 || DEPTH > 15 || W < 1) begin
         $error("crfc_stack: bad parameters");
      end
   end

   logic [W-1:0] lvl_q [DEPTH];
   logic [3:0] cnt_q;

   assign top = lvl_q[0];
   assign empty = (cnt_q == 4'h0);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            lvl_q[i] <= '0;
         end
         cnt_q <= 4'h0;
      end else if (push) begin
         // oldest level falls off the bottom when already full
         lvl_q[0] <= push_val;
         for (int i = 1; i < DEPTH; i++) begin
            lvl_q[i] <= lvl_q[i-1];
         end
         if (cnt_q != 4'(DEPTH)) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end else if (pop && !empty) begin
         // empty pop leaves the stack where it is
         for (int i = 0; i < DEPTH - 1; i++) begin
            lvl_q[i] <= lvl_q[i+1];
         end
         cnt_q <= cnt_q - 4'h1;
      end
   end

   a_stack_bound: assert property (@(posedge clock) disable iff (!rst_n)
      cnt_q <= 4'(DEPTH)) else $error("stack count over depth");
   a_stack_push: assert property (@(posedge clock) disable iff (!rst_n)
      push |=> lvl_q[0] == $past(push_val)) else $error("push not on top");
endmodule : crfc_stack
`default_nettype wire

/* verif/crfc_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module crfc_prog_mem
   import crfc_pkg::*;
(
   input wire logic [11:0] program_counter,
   output logic [7:0] fetch_byte
);
   // the byte pattern is always negative, so a relative step is always a backward branch
   assign fetch_byte = {4'hf, program_counter[3:0]};
endmodule : crfc_prog_mem
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench
   import crfc_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   crfc_dbus_t dbus = '0;
   crfc_pc_op_t pc_op = CRFC_PC_HOLD;
   crfc_fl_op_t fl_op = CRFC_FL_KEEP;
   logic [11:0] pc_target = 12'h000;
   logic [7:0] rel_offset, alu_a = 8'h00, alu_b = 8'h00, bit_src = 8'h10;
   logic alu_sub = 1'b0, short_sel_valid = 1'b0;
   logic [2:0] bit_sel = 3'h4;
   logic [1:0] short_sel = 2'h0;
   logic [7:0] dbus_rdata, short_rdata, alu_result, b;
   logic dbus_hit, short_cycles_out;
   logic [11:0] program_counter;
   crfc_flags_t active_flags;
   crfc_ctx_t context_out;
   int failures = 0;
   int check_count = 0;
   logic [7:0] addrs [5] = '{CRFC_ADDR_PTR0, CRFC_ADDR_PTR1, CRFC_ADDR_SHR0, CRFC_ADDR_SHR1, CRFC_ADDR_ACC};

   always #25 clock = ~clock;

   crfc_prog_mem crfc_prog_mem_inst (.program_counter(program_counter), .fetch_byte(rel_offset));

   crfc_core crfc_core_inst (
      .clock(clock), .rst_n(rst_n), .dbus(dbus), .dbus_rdata(dbus_rdata), .dbus_hit(dbus_hit),
      .pc_op(pc_op), .pc_target(pc_target), .rel_offset(rel_offset), .fl_op(fl_op),
      .alu_a(alu_a), .alu_b(alu_b), .alu_sub(alu_sub), .bit_sel(bit_sel), .bit_src(bit_src),
      .short_sel_valid(short_sel_valid), .short_sel(short_sel), .short_rdata(short_rdata),
      .alu_result(alu_result), .program_counter(program_counter), .active_flags(active_flags),
      .context_out(context_out), .short_cycles_out(short_cycles_out)
   );

   task automatic give_verdict();
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // every request lasts one cycle, then the bench idles; outputs are looked at on the falling edge
   task automatic op(input crfc_pc_op_t p, input logic [11:0] t);
      @(posedge clock);
      pc_op <= p;
      pc_target <= t;
      @(posedge clock);
      pc_op <= CRFC_PC_HOLD;
      @(negedge clock);
   endtask : op

   task automatic alu(input crfc_fl_op_t f, input logic [7:0] a, input logic [7:0] c, input logic s);
      @(posedge clock);
      fl_op <= f;
      alu_a <= a;
      alu_b <= c;
      alu_sub <= s;
      @(posedge clock);
      fl_op <= CRFC_FL_KEEP;
      @(negedge clock);
   endtask : alu

   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge clock);
      dbus <= '{addr: a, wr: w, wdata: d};
      @(posedge clock);
      dbus.wr <= 1'b0;
      @(negedge clock);
   endtask : bus

   initial begin
      repeat (4000) @(posedge clock);
      failures++;
      give_verdict();
   end

   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      `CHK(context_out, CRFC_CTX_NMI)
      `CHK(program_counter, CRFC_PC_RESET)
      `CHK(active_flags, 2'b00)
      for (int i = 0; i < 5; i++) bus(addrs[i], 1'b1, 8'hc1 + 8'(i));
      bus(8'h84, 1'b1, 8'h5a);
      for (int i = 0; i < 5; i++) begin
         bus(addrs[i], 1'b0, 8'h00);
         `CHK(dbus_rdata, 8'hc1 + 8'(i))
         `CHK(dbus_hit, 1'b1)
      end
      bus(8'h84, 1'b0, 8'h00);
      `CHK(dbus_rdata, 8'h00)
      `CHK(dbus_hit, 1'b0)
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         short_sel_valid <= 1'b1;
         short_sel <= 2'(i);
         @(posedge clock);
         short_sel_valid <= 1'b0;
         @(negedge clock);
         `CHK(short_rdata, 8'hc1 + 8'(i))
         `CHK(short_cycles_out, 1'b1)
      end
      op(CRFC_PC_JUMP, 12'hffe);
      `CHK(program_counter, 12'hffe)
      op(CRFC_PC_INC, 12'h000);
      `CHK(program_counter, 12'hfff)
      op(CRFC_PC_INC, 12'h000);
      `CHK(program_counter, 12'h000)
      op(CRFC_PC_JUMP, 12'h23a);
      b = rel_offset;
      op(CRFC_PC_REL, 12'h000);
      `CHK(program_counter, 12'h23a + {{4{b[7]}}, b})
      op(CRFC_PC_JUMP, 12'h050);
      for (int i = 0; i < 7; i++) op(CRFC_PC_CALL, 12'h100 + 12'(i));
      `CHK(program_counter, 12'h106)
      for (int i = 5; i >= 0; i--) begin
         op(CRFC_PC_RET, 12'h000);
         `CHK(program_counter, 12'h100 + 12'(i))
      end
      op(CRFC_PC_RET, 12'h000);
      `CHK(program_counter, 12'h101)
      alu(CRFC_FL_ARITH, 8'hff, 8'h01, 1'b0);
      `CHK(alu_result, 8'h00)
      `CHK(active_flags, 2'b11)
      alu(CRFC_FL_KEEP, 8'h10, 8'h20, 1'b0);
      `CHK(active_flags, 2'b11)
      alu(CRFC_FL_ARITH, 8'h01, 8'h02, 1'b1);
      `CHK(alu_result, 8'hff)
      `CHK(active_flags, 2'b10)
      alu(CRFC_FL_ARITH, 8'h10, 8'h20, 1'b0);
      `CHK(active_flags, 2'b00)
      alu(CRFC_FL_LOGIC, 8'hf0, 8'h0f, 1'b0);
      `CHK(active_flags.zero, 1'b1)
      alu(CRFC_FL_BITTEST, 8'h00, 8'h00, 1'b0);
      `CHK(active_flags.carry, 1'b1)
      alu(CRFC_FL_ROTL, 8'h81, 8'h00, 1'b0);
      `CHK(alu_result, 8'h03)
      `CHK(active_flags.carry, 1'b1)
      alu(CRFC_FL_ARITH, 8'h01, 8'h02, 1'b1);
      op(CRFC_PC_JUMP, 12'h345);
      op(CRFC_PC_IRQ, 12'h000);
      `CHK(context_out, CRFC_CTX_IRQ)
      `CHK(program_counter, 12'hff0)
      `CHK(active_flags, 2'b00)
      alu(CRFC_FL_ARITH, 8'h80, 8'h80, 1'b0);
      `CHK(active_flags, 2'b11)
      op(CRFC_PC_INTERRUPT_RETURN_INSTR, 12'h000);
      `CHK(context_out, CRFC_CTX_NMI)
      `CHK(program_counter, 12'h345)
      `CHK(active_flags, 2'b10)
      op(CRFC_PC_IRQ, 12'h000);
      `CHK(active_flags, 2'b11)
      op(CRFC_PC_INTERRUPT_RETURN_INSTR, 12'h000);
      `CHK(active_flags, 2'b10)
      op(CRFC_PC_INTERRUPT_RETURN_INSTR, 12'h000);
      `CHK(context_out, CRFC_CTX_NORMAL)
      `CHK(program_counter, 12'h346)
      `CHK(active_flags, 2'b00)
      alu(CRFC_FL_ARITH, 8'h00, 8'h00, 1'b0);
      `CHK(active_flags, 2'b01)
      op(CRFC_PC_NMI, 12'h000);
      `CHK(context_out, CRFC_CTX_NMI)
      `CHK(program_counter, 12'hffc)
      `CHK(active_flags, 2'b10)
      op(CRFC_PC_INTERRUPT_RETURN_INSTR, 12'h000);
      `CHK(context_out, CRFC_CTX_NORMAL)
      `CHK(program_counter, 12'h346)
      `CHK(active_flags, 2'b01)
      // back-to-back requests: call then return, then nmi entry then interrupt return
      @(posedge clock);
      pc_op <= CRFC_PC_CALL;
      pc_target <= 12'h200;
      @(posedge clock);
      pc_op <= CRFC_PC_RET;
      @(posedge clock);
      pc_op <= CRFC_PC_NMI;
      @(posedge clock);
      pc_op <= CRFC_PC_INTERRUPT_RETURN_INSTR;
      @(posedge clock);
      pc_op <= CRFC_PC_HOLD;
      @(negedge clock);
      `CHK(program_counter, 12'h346)
      `CHK(context_out, CRFC_CTX_NORMAL)
      `CHK(active_flags, 2'b01)
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
